// file: logic/bms_params.svh
/*
 * Constants of the broadcast message scheduler: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included by bare name from files that use the macros.
 */
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define BMS_ADDR_FID_LO   8'h00
`define BMS_ADDR_FID_HI   8'h04
`define BMS_ADDR_CAP_LO   8'h08
`define BMS_ADDR_CAP_HI   8'h0C
`define BMS_ADDR_CTRL     8'h10
`define BMS_ADDR_STAT     8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BMS_CTRL_ENH_BIT  0
`define BMS_CTRL_ACAS_BIT 1
`define BMS_CTRL_RESET    2'h0
`define BMS_HI_W          24
`define BMS_MB_W          56
`define BMS_DR_NONE       3'h0
`define BMS_DR_BASE       3'h4
`define BMS_DR_ACAS_OFS   3'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BMS_HOLD_S        18
`define BMS_SECOND_NS     1000000000
`define BMS_CLK_PERIOD_NS 10
`define BMS_CLKS_PER_SEC  (`BMS_SECOND_NS / `BMS_CLK_PERIOD_NS)

`endif

// file: logic/bms_pkg.sv
/*
 * Types shared by the broadcast message scheduler files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bms_pkg;

    // Scheduler states, one-hot
    typedef enum logic [1:0] {
        BMS_IDLE   = 2'b01,
        BMS_ACTIVE = 2'b10
    } bms_state_type;

    // Broadcast message sources
    typedef enum logic {
        BMS_SRC_FID = 1'b0,
        BMS_SRC_CAP = 1'b1
    } bms_src_type;

endpackage

// file: logic/bms_hold_timer.sv
/*
 * One hold timer of the broadcast scheduler, counting whole seconds.
 * Assumes a one-cycle seconds tick and an air-initiated busy level, both
 * from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"

module bms_hold_timer #(
    parameter int HOLD_S = `BMS_HOLD_S
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic tick_sec,
    input  wire logic start,
    input  wire logic air_busy,
    output logic      live,
    output logic      avail
);

    localparam int CW = $clog2(HOLD_S + 1);

    logic [CW-1:0] count;
    logic          susp;

    // ------------------------------------------------------------------
    // Count down; an air transaction clears and parks, its end reloads
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count <= '0;
            susp  <= 1'b0;
        end else if (start) begin
            count <= CW'(HOLD_S);
            susp  <= 1'b0;
        end else if (air_busy && (count != '0 || susp)) begin
            count <= '0;
            susp  <= 1'b1;
        end else if (susp) begin
            count <= CW'(HOLD_S);
            susp  <= 1'b0;
        end else if (tick_sec && count != '0) begin
            count <= count - CW'(1);
        end
    end

    // Live until expiry, offered only outside air transactions
    assign live  = (count != '0) || susp;
    assign avail = (count != '0) && !susp && !air_busy;

endmodule

`default_nettype wire

// file: logic/bms_scheduler.sv
/*
 * Broadcast message scheduler: queues flight identification and capability
 * report broadcasts, announces them with alternating codes and holds each
 * for the hold time, yielding to air-initiated transactions.
 * Assumes a register master on clk_sys and air-busy levels per interrogator
 * code from the transaction logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"

// Functional notes
// - Start broadcast only with no air transaction
// - New broadcast never preempts the current one
// - Expiry drops message and toggles message number
// - Next broadcast uses the alternate code
// - Hold timer starts when message becomes current
// - Air transaction stops, clears the hold timer
// - After air transaction, fresh full hold time
// - No broadcast code during air transaction in basic mode; enhanced hides only interrupted codes
// - Waiting broadcasts queued until current finishes
// - Queued source keeps only its latest value
// - Only flight ident and capability report broadcast
// - Enhanced mode tracks interruption per interrogator code
// - Enhanced: next only after all timers expire
// - Writing a new value starts a broadcast
// - Rewriting the sent value starts no broadcast
// - Queued broadcasts served in arrival order
// - Broadcast ends only by timer expiry
module bms_scheduler #(
    parameter int N_II         = 16,
    parameter int HOLD_S       = `BMS_HOLD_S,
    parameter int CLKS_PER_SEC = `BMS_CLKS_PER_SEC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic [7:0]           addr,
    input  wire logic [31:0]          wr_data,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic      [31:0]          rd_data,
    input  wire logic [N_II-1:0]      air_active,
    output logic      [2:0]           bcast_dr_code,
    output logic      [N_II-1:0]      bcast_avail,
    output logic      [`BMS_MB_W-1:0] bcast_mb,
    output logic                      bcast_msg_two
);

    localparam int PW = $clog2(CLKS_PER_SEC);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (N_II < 1 || N_II > 16) begin : g_bad_ii
        $error("bms_scheduler: N_II must be 1 to 16");
    end
    if (CLKS_PER_SEC < 2 || HOLD_S < 1) begin : g_bad_time
        $error("bms_scheduler: CLKS_PER_SEC or HOLD_S out of range");
    end

    // Commit decode: a write to the high word completes a source value
    function automatic logic bms_commit(input logic [7:0] a, input logic s);
        bms_commit = (s ? (a == `BMS_ADDR_CAP_HI) : (a == `BMS_ADDR_FID_HI));
    endfunction

    bms_pkg::bms_state_type state;
    bms_pkg::bms_src_type   cur_src;
    bms_pkg::bms_src_type   head;
    logic [1:0]             ctrl;
    logic [PW-1:0]          presc;
    logic                   tick_sec;
    logic [1:0]             pend;
    logic [1:0]             next_pend;
    logic [1:0]             set_new;
    logic [1:0]             sent_valid;
    logic [31:0]            lo_val [2];
    logic [`BMS_MB_W-1:0]   new_val [2];
    logic [`BMS_MB_W-1:0]   qval [2];
    logic [`BMS_MB_W-1:0]   last_sent [2];
    logic [`BMS_MB_W-1:0]   head_val;
    logic                   take;
    logic                   finish;
    logic                   any_air;
    logic [N_II-1:0]        air_busy;
    logic [N_II-1:0]        live;
    logic [N_II-1:0]        avail;
    logic [2:0]             dr_val;
    logic [31:0]            next_rd;

    // ------------------------------------------------------------------
    // Seconds time base
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            presc    <= '0;
            tick_sec <= 1'b0;
        end else if (presc == PW'(CLKS_PER_SEC - 1)) begin
            presc    <= '0;
            tick_sec <= 1'b1;
        end else begin
            presc    <= presc + PW'(1);
            tick_sec <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= `BMS_CTRL_RESET;
        end else if (wr_en && addr == `BMS_ADDR_CTRL) begin
            ctrl <= wr_data[1:0];
        end
    end

    // Start and finish conditions of the current broadcast
    assign any_air  = |air_active;
    assign take     = (state == bms_pkg::BMS_IDLE) && (|pend) && !any_air;
    assign finish   = (state == bms_pkg::BMS_ACTIVE) && !(|live);
    assign head_val = qval[head];

    // ------------------------------------------------------------------
    // Per-source queue: staging word, latest value, sent-value filter
    // ------------------------------------------------------------------
    for (genvar s = 0; s < 2; s++) begin : g_src
        logic commit;
        logic same_as_sent;
        logic taken;

        assign commit       = wr_en && bms_commit(addr, 1'(s));
        assign new_val[s]   = {wr_data[`BMS_HI_W-1:0], lo_val[s]};
        assign same_as_sent = sent_valid[s] && (new_val[s] == last_sent[s]);
        assign taken        = take && (head == bms_pkg::bms_src_type'(s));
        assign set_new[s]   = commit && !pend[s] && !same_as_sent;

        // Pending wins over the take of an older value in the same cycle
        always_comb begin
            next_pend[s] = pend[s];
            if (taken) begin
                next_pend[s] = 1'b0;
            end
            if (commit && (pend[s] || !same_as_sent)) begin
                next_pend[s] = 1'b1;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                lo_val[s] <= 32'h0000_0000;
            end else if (wr_en && addr == (s ? `BMS_ADDR_CAP_LO : `BMS_ADDR_FID_LO)) begin
                lo_val[s] <= wr_data;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                pend[s] <= 1'b0;
                qval[s] <= '0;
            end else begin
                pend[s] <= next_pend[s];
                if (commit && (pend[s] || !same_as_sent)) begin
                    qval[s] <= new_val[s];
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                sent_valid[s] <= 1'b0;
                last_sent[s]  <= '0;
            end else if (taken) begin
                sent_valid[s] <= 1'b1;
                last_sent[s]  <= qval[s];
            end
        end
    end

    // ------------------------------------------------------------------
    // Arrival order of the two sources
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            head <= bms_pkg::BMS_SRC_FID;
        end else if (next_pend == 2'b01) begin
            head <= bms_pkg::BMS_SRC_FID;
        end else if (next_pend == 2'b10) begin
            head <= bms_pkg::BMS_SRC_CAP;
        end else if (take && next_pend == 2'b11) begin
            head <= (head == bms_pkg::BMS_SRC_FID) ? bms_pkg::BMS_SRC_CAP
                                                   : bms_pkg::BMS_SRC_FID;
        end
    end

    // ------------------------------------------------------------------
    // Broadcast sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state         <= bms_pkg::BMS_IDLE;
            cur_src       <= bms_pkg::BMS_SRC_FID;
            bcast_mb      <= '0;
            bcast_msg_two <= 1'b0;
        end else begin
            unique case (state)
                bms_pkg::BMS_IDLE: begin
                    if (take) begin
                        state    <= bms_pkg::BMS_ACTIVE;
                        cur_src  <= head;
                        bcast_mb <= head_val;
                    end
                end
                bms_pkg::BMS_ACTIVE: begin
                    if (finish) begin
                        state         <= bms_pkg::BMS_IDLE;
                        bcast_mb      <= '0;
                        bcast_msg_two <= !bcast_msg_two;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Hold timers, one per interrogator code
    // ------------------------------------------------------------------
    for (genvar i = 0; i < N_II; i++) begin : g_ii
        // Basic mode: any air transaction interrupts every code
        assign air_busy[i] = ctrl[`BMS_CTRL_ENH_BIT] ? air_active[i] : any_air;

        bms_hold_timer #(
            .HOLD_S   (HOLD_S)
        ) u_timer (
            .clk_sys  (clk_sys),
            .reset    (reset),
            .tick_sec (tick_sec),
            .start    (take),
            .air_busy (air_busy[i]),
            .live     (live[i]),
            .avail    (avail[i])
        );
    end

    // Announcement code from message number and collision-avoidance flag
    assign dr_val = `BMS_DR_BASE
                  + (ctrl[`BMS_CTRL_ACAS_BIT] ? `BMS_DR_ACAS_OFS : `BMS_DR_NONE)
                  + {2'b00, bcast_msg_two};

    // ------------------------------------------------------------------
    // Announcement outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bcast_avail   <= '0;
            bcast_dr_code <= `BMS_DR_NONE;
        end else if (state == bms_pkg::BMS_ACTIVE && |avail) begin
            bcast_avail   <= avail;
            bcast_dr_code <= dr_val;
        end else begin
            bcast_avail   <= '0;
            bcast_dr_code <= `BMS_DR_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Read path: data in the cycle after the strobe only
    // ------------------------------------------------------------------
    always_comb begin
        next_rd = 32'h0000_0000;
        unique case (addr)
            `BMS_ADDR_FID_LO: next_rd = qval[0][31:0];
            `BMS_ADDR_FID_HI: next_rd = {8'h00, qval[0][`BMS_MB_W-1:32]};
            `BMS_ADDR_CAP_LO: next_rd = qval[1][31:0];
            `BMS_ADDR_CAP_HI: next_rd = {8'h00, qval[1][`BMS_MB_W-1:32]};
            `BMS_ADDR_CTRL:   next_rd = {30'h0000_0000, ctrl};
            `BMS_ADDR_STAT:   next_rd = {21'h00_0000, bcast_dr_code, 1'b0, head,
                                         pend, 1'b0, cur_src, bcast_msg_two,
                                         state == bms_pkg::BMS_ACTIVE};
            default:          next_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= rd_en ? next_rd : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [7:0] hold_secs;

    // Seconds during which code 0 has been offered without a break
    always_ff @(posedge clk_sys) begin
        if (reset || !bcast_avail[0]) begin
            hold_secs <= 8'h00;
        end else if (tick_sec && hold_secs != 8'hFF) begin
            hold_secs <= hold_secs + 8'h01;
        end
    end

    property p_start;
        @(posedge clk_sys) disable iff (reset)
        take |=> state == bms_pkg::BMS_ACTIVE && bcast_mb == $past(head_val);
    endproperty
    a_start: assert property (p_start) else $error("broadcast start lost");

    property p_no_preempt;
        @(posedge clk_sys) disable iff (reset)
        state == bms_pkg::BMS_ACTIVE && |live |=> state == bms_pkg::BMS_ACTIVE && $stable(bcast_mb);
    endproperty
    a_no_preempt: assert property (p_no_preempt) else $error("broadcast preempted");

    property p_expire;
        @(posedge clk_sys) disable iff (reset)
        finish |=> state == bms_pkg::BMS_IDLE && bcast_mb == '0 && bcast_msg_two != $past(bcast_msg_two);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry handling wrong");

    property p_alt_code;
        @(posedge clk_sys) disable iff (reset)
        |bcast_avail |-> bcast_dr_code[2] && bcast_dr_code[0] == bcast_msg_two;
    endproperty
    a_alt_code: assert property (p_alt_code) else $error("code does not follow number");

    property p_air_quiet;
        @(posedge clk_sys) disable iff (reset)
        !ctrl[`BMS_CTRL_ENH_BIT] && any_air |=> bcast_dr_code == `BMS_DR_NONE && bcast_avail == '0;
    endproperty
    a_air_quiet: assert property (p_air_quiet) else $error("code shown during air transaction");

    property p_ii_quiet;
        @(posedge clk_sys) disable iff (reset)
        ctrl[`BMS_CTRL_ENH_BIT] && air_active[0] |=> !bcast_avail[0];
    endproperty
    a_ii_quiet: assert property (p_ii_quiet) else $error("code 0 offered while interrupted");

    property p_hold_len;
        @(posedge clk_sys) disable iff (reset)
        hold_secs <= 8'(HOLD_S);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold time overrun");

    property p_latest;
        @(posedge clk_sys) disable iff (reset)
        wr_en && bms_commit(addr, 1'b0) && pend[0] |=> pend[0] && qval[0] == $past(new_val[0]);
    endproperty
    a_latest: assert property (p_latest) else $error("queued value not latest");

    property p_same_skip;
        @(posedge clk_sys) disable iff (reset)
        wr_en && bms_commit(addr, 1'b1) && !pend[1] && sent_valid[1]
            && new_val[1] == last_sent[1] |=> !pend[1];
    endproperty
    a_same_skip: assert property (p_same_skip) else $error("repeat value queued");

    property p_order;
        @(posedge clk_sys) disable iff (reset)
        take && next_pend == 2'b11 |=> head != $past(head);
    endproperty
    a_order: assert property (p_order) else $error("arrival order broken");

    property p_reset;
        @(posedge clk_sys)
        reset |=> state == bms_pkg::BMS_IDLE && pend == 2'b00 && !bcast_msg_two
            && bcast_dr_code == `BMS_DR_NONE && live == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule

`default_nettype wire

// file: bench/bms_air_model.sv
/*
 * Far side model: air-initiated transactions per interrogator code, and a
 * listening interrogator that fetches each newly announced broadcast.
 * Assumes bench commands and scheduler outputs on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module bms_air_model #(
    parameter int N_II = 4
) (
    input  wire logic            clk_sys,
    input  wire logic            reset,
    input  wire logic            go,
    input  wire logic [N_II-1:0] go_mask,
    input  wire logic [15:0]     go_len,
    input  wire logic [2:0]      dr_code,
    input  wire logic [55:0]     mb,
    output logic      [N_II-1:0] air_active,
    output logic      [55:0]     got_mb
);
    // ----------------------------------------------------------------
    // Transactions and pickup
    // ----------------------------------------------------------------
    logic [15:0] left;
    logic [2:0]  last_dr;
    // Holds the air transaction for the commanded count of cycles
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            air_active <= '0;
            left       <= 16'h0000;
        end else if (go) begin
            air_active <= go_mask;
            left       <= go_len;
        end else if (left > 16'h0001) begin
            left <= left - 16'h0001;
        end else begin
            air_active <= '0;
            left       <= 16'h0000;
        end
    end
    // A changed nonzero code means a new broadcast, so fetch it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            last_dr <= 3'h0;
            got_mb  <= 56'h0;
        end else begin
            last_dr <= dr_code;
            if (dr_code != last_dr && dr_code != 3'h0) begin
                got_mb <= mb;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/broadcast_message_scheduler_tb.sv
/*
 * Self-checking bench of the broadcast scheduler, random messages.
 * Assumes the scheduler, its header and the far side model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"
module broadcast_message_scheduler_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int NI = 4;
    localparam int HS = 3;
    localparam int CPS = 10;
    localparam int LO = (HS - 1) * CPS;
    localparam int HI = HS * CPS + 4;
    logic          clk_sys, reset, wr_en, rd_en, go, two, acas;
    logic [7:0]    addr;
    logic [31:0]   wr_data, rd_data, seed;
    logic [NI-1:0] air_active, bcast_avail, go_mask;
    logic [15:0]   go_len;
    logic [2:0]    bcast_dr_code;
    logic [55:0]   bcast_mb, got_mb;
    logic          bcast_msg_two;
    int            errors, checked, cyc, t_on;

    bms_scheduler #(.N_II(NI), .HOLD_S(HS), .CLKS_PER_SEC(CPS)) bms_scheduler_inst (
        .clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .air_active(air_active), .bcast_dr_code(bcast_dr_code),
        .bcast_avail(bcast_avail), .bcast_mb(bcast_mb), .bcast_msg_two(bcast_msg_two));
    bms_air_model #(.N_II(NI)) bms_air_model_inst (
        .clk_sys(clk_sys), .reset(reset), .go(go), .go_mask(go_mask), .go_len(go_len),
        .dr_code(bcast_dr_code), .mb(bcast_mb), .air_active(air_active), .got_mb(got_mb));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Clock at 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Cycle count and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            $display("[ERR] run time expected below 5000 seen %0d", cyc);
            test_done();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [55:0] msg();
        logic [31:0] a;
        logic [31:0] b;
        a = xs();
        b = xs();
        return {a[23:0], b};
    endfunction
    function automatic logic [2:0] exp_dr();
        return `BMS_DR_BASE + {1'b0, acas, 1'b0} + {2'b00, two};
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input int lo, input int hi, input int g);
        checked++;
        if (g < lo || g > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk("rd_data", e, rd_data);
    endtask
    task automatic put(input logic [7:0] a, input logic [55:0] v);
        wr(a, v[31:0]);
        wr(a + 8'h04, {8'h00, v[55:32]});
    endtask
    task automatic air(input logic [NI-1:0] m, input logic [15:0] l);
        @(posedge clk_sys);
        go      <= 1'b1;
        go_mask <= m;
        go_len  <= l;
        @(posedge clk_sys);
        go      <= 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_on();
        for (int k = 0; k < 200 && bcast_dr_code === 3'h0; k++) step(1);
        t_on = cyc;
    endtask
    task automatic announce(input logic [55:0] v, input logic [NI-1:0] av);
        step(1);
        chk("dr_code", exp_dr(), bcast_dr_code);
        chk("mb", v, bcast_mb);
        chk("avail", av, bcast_avail);
        chk("fetched", v, got_mb);
    endtask
    task automatic finish_hold(input int lo, input int hi);
        for (int k = 0; k < 2000 && bcast_dr_code !== 3'h0; k++) step(1);
        chk_rng("hold", lo, hi, cyc - t_on);
        two = ~two;
        step(2);
        chk("msg_two", two, bcast_msg_two);
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [55:0] f1, c1, f2, f3, f4, c2, f5, c3, f6;
        {reset, wr_en, rd_en, go, two, acas} = 6'h20;
        {addr, wr_data, go_mask, go_len, errors, checked, cyc} = '0;
        seed = 32'h0000_569E;
        f1 = msg();
        c1 = msg();
        f2 = msg();
        f3 = msg();
        f4 = msg();
        c2 = msg();
        f5 = msg();
        c3 = msg();
        f6 = msg();
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        step(1);
        chk("dr_code", 3'h0, bcast_dr_code);
        chk("msg_two", 1'b0, bcast_msg_two);
        rd_chk(`BMS_ADDR_STAT, 32'h0);
        rd_chk(8'h3C, 32'h0);
        $display("test reset done");
        put(`BMS_ADDR_FID_LO, f1);
        wait_on();
        announce(f1, '1);
        put(`BMS_ADDR_CAP_LO, c1);
        put(`BMS_ADDR_FID_LO, f2);
        put(`BMS_ADDR_FID_LO, f3);
        chk("mb", f1, bcast_mb);
        rd_chk(`BMS_ADDR_FID_LO, f3[31:0]);
        finish_hold(LO, HI);
        wait_on();
        announce(c1, '1);
        finish_hold(LO, HI);
        wait_on();
        announce(f3, '1);
        finish_hold(LO, HI);
        put(`BMS_ADDR_FID_LO, f3);
        step(10);
        chk("dr_code", 3'h0, bcast_dr_code);
        chk("mb", 56'h0, bcast_mb);
        $display("test queue done");
        air(4'hF, 16'h0028);
        put(`BMS_ADDR_FID_LO, f4);
        put(`BMS_ADDR_CAP_LO, c3);
        wr(`BMS_ADDR_FID_LO, f6[31:0]);
        step(4);
        chk("dr_code", 3'h0, bcast_dr_code);
        // Recommit the head source on the very edge that takes it
        step(25);
        wr(`BMS_ADDR_FID_HI, {8'h00, f6[55:32]});
        wait_on();
        announce(f4, '1);
        step(5);
        air(4'h2, 16'h000F);
        step(4);
        chk("dr_code", 3'h0, bcast_dr_code);
        chk("avail", 4'h0, bcast_avail);
        wait_on();
        chk("dr_code", exp_dr(), bcast_dr_code);
        finish_hold(LO, HI);
        wait_on();
        announce(c3, '1);
        finish_hold(LO, HI);
        wait_on();
        announce(f6, '1);
        finish_hold(LO, HI);
        $display("test air done");
        wr(`BMS_ADDR_CTRL, 32'h3);
        acas = 1'b1;
        rd_chk(`BMS_ADDR_CTRL, 32'h3);
        put(`BMS_ADDR_CAP_LO, c2);
        wait_on();
        announce(c2, '1);
        put(`BMS_ADDR_FID_LO, f5);
        air(4'h1, 16'h000F);
        step(4);
        chk("avail", 4'hE, bcast_avail);
        step(t_on + HI + 4 - cyc);
        chk("avail", 4'h1, bcast_avail);
        chk("mb", c2, bcast_mb);
        finish_hold(LO + 20, 100);
        wait_on();
        announce(f5, '1);
        finish_hold(LO, HI);
        put(`BMS_ADDR_CAP_LO, c2);
        step(10);
        chk("dr_code", 3'h0, bcast_dr_code);
        $display("test enhanced done");
        test_done();
    end
endmodule
`default_nettype wire
